// ### verilog/scs_pkg.sv
`default_nettype none
package scs_pkg;
  localparam int unsigned SCS_NBITS      = 16;
  localparam int unsigned SCS_CLK_MHZ    = 125;
  // shortest spacing of starts at the top rate, in ns
  localparam int unsigned SCS_PERIOD_NS  = 4000;
  localparam int unsigned SCS_PERIOD_CYC = SCS_PERIOD_NS * SCS_CLK_MHZ / 1000;
  // settle time between bottom-plate open and array grounding
  localparam int unsigned SCS_SETTLE_CYC = 1;
  // idle cycles per trial: the comparator reaches the decision two flops late
  localparam logic [1:0]  SCS_CMP_WAIT   = 2'h2;
  localparam logic [15:0] SCS_CODE_RST   = 16'h0000;
  localparam logic [15:0] SCS_CODE_MAX   = 16'hFFFF;
  localparam logic [15:0] SCS_CODE_MIN   = 16'h0000;

  typedef enum logic [2:0] {
    SCS_ACQ    = 3'b000,
    SCS_OPEN   = 3'b001,
    SCS_HOLD   = 3'b010,
    SCS_SEARCH = 3'b011,
    SCS_DONE   = 3'b100
  } scs_state_t;

  // switch drive toward the analog array
  typedef struct packed {
    logic        plate_pos;
    logic        plate_neg;
    logic        track;
    logic        gnd;
    logic [15:0] ref_sel;
  } scs_sw_t;
endpackage : scs_pkg
`default_nettype wire

// ### verilog/scs_sequencer.sv
// Functional notes
// - convert_start rising edge ends acquisition and starts a conversion.
// - open bottom-plate switches first, then ground both arrays.
// - sixteen binary-weighted trial steps, most significant bit first.
// - after search: power down, reacquire, present code, pulse completion.
// - conversion timed by internal clock only, no serial clock needed.
// - each result belongs to its own sample, no pipeline delay.
// - result is 16-bit straight binary, zero gives 0000.
// - input above reference gives FFFF, saturating.
// - input below ground gives 0000, saturating.
// - supports 250 kSPS and powers down between conversions.
// - started conversion completes regardless of convert_start changes.
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
  parameter int unsigned NBITS = scs_pkg::SCS_NBITS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // host
  input  wire logic               convert_start,
  output logic                    busy,
  output logic                    done,
  output logic [NBITS-1:0]        result,
  // analog array
  input  wire logic               comp_high,
  input  wire logic               over_range,
  input  wire logic               under_range,
  output scs_pkg::scs_sw_t        sw,
  output logic                    power_on
);
  // async pins: two-flop synchronisers
  logic [2:0] cnv_sync_ff;
  logic [2:0] nxt_cnv_sync;
  logic [1:0] cmp_sync_ff;
  logic [1:0] nxt_cmp_sync;
  logic [1:0] ovr_sync_ff;
  logic [1:0] nxt_ovr_sync;
  logic [1:0] und_sync_ff;
  logic [1:0] nxt_und_sync;
  logic       cnv_rise;

  always_comb begin
    nxt_cnv_sync = {cnv_sync_ff[1:0], convert_start};
    nxt_cmp_sync = {cmp_sync_ff[0], comp_high};
    nxt_ovr_sync = {ovr_sync_ff[0], over_range};
    nxt_und_sync = {und_sync_ff[0], under_range};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnv_sync_ff <= 3'h0;
      cmp_sync_ff <= 2'h0;
      ovr_sync_ff <= 2'h0;
      und_sync_ff <= 2'h0;
    end else begin
      cnv_sync_ff <= nxt_cnv_sync;
      cmp_sync_ff <= nxt_cmp_sync;
      ovr_sync_ff <= nxt_ovr_sync;
      und_sync_ff <= nxt_und_sync;
    end
  end

  // edge from second and third stage only
  assign cnv_rise = cnv_sync_ff[1] & ~cnv_sync_ff[2];

  // sequencer state
  scs_pkg::scs_state_t state_ff;
  scs_pkg::scs_state_t nxt_state;
  logic [NBITS-1:0]    trial_ff;
  logic [NBITS-1:0]    nxt_trial;
  logic [NBITS-1:0]    bit_ff;
  logic [NBITS-1:0]    nxt_bit;
  logic [NBITS-1:0]    result_ff;
  logic [NBITS-1:0]    nxt_result;
  logic                done_ff;
  logic                nxt_done;
  logic [1:0]          wait_ff;
  logic [1:0]          nxt_wait;

  always_comb begin
    nxt_state  = state_ff;
    nxt_trial  = trial_ff;
    nxt_bit    = bit_ff;
    nxt_result = result_ff;
    nxt_done   = 1'b0;
    nxt_wait   = 2'h0;
    case (state_ff)
      scs_pkg::SCS_ACQ: begin
        if (cnv_rise) begin
          nxt_state = scs_pkg::SCS_OPEN;
        end
      end
      scs_pkg::SCS_OPEN: begin
        // plates open one cycle before arrays leave inputs
        nxt_state = scs_pkg::SCS_HOLD;
      end
      scs_pkg::SCS_HOLD: begin
        nxt_state = scs_pkg::SCS_SEARCH;
        nxt_bit   = {1'b1, {(NBITS-1){1'b0}}};
        nxt_trial = {1'b1, {(NBITS-1){1'b0}}};
        nxt_wait  = scs_pkg::SCS_CMP_WAIT;
      end
      scs_pkg::SCS_SEARCH: begin
        // two flops on the comparator: deciding earlier reads a stale trial
        if (wait_ff != 2'h0) begin
          nxt_wait = wait_ff - 2'h1;
        end else begin
          nxt_wait = scs_pkg::SCS_CMP_WAIT;
          if (cmp_sync_ff[1]) begin
            nxt_trial = trial_ff & ~bit_ff;
          end
          nxt_bit = bit_ff >> 1;
          if (bit_ff[0]) begin
            nxt_state = scs_pkg::SCS_DONE;
            nxt_wait  = 2'h0;
          end else begin
            nxt_trial = (cmp_sync_ff[1] ? (trial_ff & ~bit_ff) : trial_ff)
                        | (bit_ff >> 1);
          end
        end
      end
      scs_pkg::SCS_DONE: begin
        // straight binary; clamp at both range ends
        if (ovr_sync_ff[1]) begin
          nxt_result = scs_pkg::SCS_CODE_MAX;
        end else if (und_sync_ff[1]) begin
          nxt_result = scs_pkg::SCS_CODE_MIN;
        end else begin
          nxt_result = trial_ff;
        end
        nxt_done  = 1'b1;
        nxt_state = scs_pkg::SCS_ACQ;
      end
      default: begin
        nxt_state = scs_pkg::SCS_ACQ;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= scs_pkg::SCS_ACQ;
      trial_ff  <= {NBITS{1'b0}};
      bit_ff    <= {NBITS{1'b0}};
      result_ff <= scs_pkg::SCS_CODE_RST;
      done_ff   <= 1'b0;
      wait_ff   <= 2'h0;
    end else begin
      state_ff  <= nxt_state;
      trial_ff  <= nxt_trial;
      bit_ff    <= nxt_bit;
      result_ff <= nxt_result;
      done_ff   <= nxt_done;
      wait_ff   <= nxt_wait;
    end
  end

  // outputs; array idle in acquisition saves power
  assign busy     = (state_ff != scs_pkg::SCS_ACQ);
  assign power_on = busy;
  assign done     = done_ff;
  assign result   = result_ff;

  always_comb begin
    sw.plate_pos = (state_ff == scs_pkg::SCS_ACQ);
    sw.plate_neg = (state_ff == scs_pkg::SCS_ACQ);
    sw.track     = (state_ff == scs_pkg::SCS_ACQ) ||
                   (state_ff == scs_pkg::SCS_OPEN);
    sw.gnd       = !sw.track;
    sw.ref_sel   = (state_ff == scs_pkg::SCS_SEARCH) ? trial_ff : 16'h0000;
  end

  AST_OPEN_BEFORE_GND: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sw.track) |-> !sw.plate_pos && $past(!sw.plate_pos))
    else $error("arrays grounded before plates opened");

  sequence s_start;
    state_ff == scs_pkg::SCS_ACQ && cnv_rise;
  endsequence
  sequence s_search_begin;
    state_ff == scs_pkg::SCS_SEARCH && trial_ff == 16'h8000;
  endsequence

  AST_START: assert property (@(posedge clk) disable iff (!rst_n)
    s_start |=> state_ff == scs_pkg::SCS_OPEN ##1 state_ff ==
      scs_pkg::SCS_HOLD ##1 s_search_begin)
    else $error("conversion did not start");

  AST_RUN_TO_END: assert property (@(posedge clk) disable iff (!rst_n)
    s_start |=> busy [*8] ##43 busy)
    else $error("conversion aborted");

  AST_DONE_TIME: assert property (@(posedge clk) disable iff (!rst_n)
    s_start |-> ##52 done)
    else $error("conversion length wrong");

  AST_RATE: assert property (@(posedge clk) disable iff (!rst_n)
    s_start |-> ##52 !busy && !power_on)
    else $error("not powered down after conversion");

  AST_OVR: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == scs_pkg::SCS_DONE && ovr_sync_ff[1] |=> result == 16'hFFFF)
    else $error("over-range not clamped");

  AST_UND: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == scs_pkg::SCS_DONE && !ovr_sync_ff[1] && und_sync_ff[1]
    |=> result == 16'h0000)
    else $error("under-range not clamped");

  AST_CODE: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == scs_pkg::SCS_DONE && !ovr_sync_ff[1] && !und_sync_ff[1]
    |=> result == $past(trial_ff) && done)
    else $error("code not straight binary of search");

  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !done |-> $stable(result))
    else $error("result moved outside completion");

  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> !busy && $past(state_ff == scs_pkg::SCS_DONE) ##1 !done)
    else $error("completion not a single pulse in acquisition");
endmodule : scs_sequencer
`default_nettype wire

// ### tb/scs_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_array_model (
  // array drive
  input  wire logic             clk,
  input  wire scs_pkg::scs_sw_t sw,
  input  wire logic [15:0]      vin,
  // comparator
  output logic                  comp_high
);
  logic [15:0] held_ff;
  // sample frozen once the arrays leave the inputs
  always_ff @(posedge clk) begin
    if (sw.track) held_ff <= vin;
  end
  // trial above held sample means the bit is cleared
  assign comp_high = sw.ref_sel > held_ff;
endmodule : scs_array_model
`default_nettype wire

// ### tb/sar_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module sar_conversion_sequencer_tb;
  logic             clk = 0;
  logic             rst_n = 0;
  logic             convert_start = 0;
  logic             over_range = 0;
  logic             under_range = 0;
  logic             busy, done, power_on, comp_high;
  logic [15:0]      result;
  logic [15:0]      vin = 16'h0000;
  logic [15:0]      lfsr = 16'h000F;
  scs_pkg::scs_sw_t sw;
  int               n_fail = 0;
  int               n_checks = 0;
  logic [15:0]      corner [6] = '{16'h0000, 16'h0001, 16'h7FFF,
                                   16'h8000, 16'h8001, 16'hFFFF};

  always #4 clk = ~clk;

  scs_sequencer DUT (.clk(clk), .rst_n(rst_n), .convert_start(convert_start),
    .busy(busy), .done(done), .result(result), .comp_high(comp_high),
    .over_range(over_range), .under_range(under_range), .sw(sw),
    .power_on(power_on));
  scs_array_model ARR (.clk(clk), .sw(sw), .vin(vin),
    .comp_high(comp_high));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // over-range wins when both flags stand
  function automatic logic [15:0] expect_code(input logic [15:0] v,
                                              input logic o, u);
    if (o) return scs_pkg::SCS_CODE_MAX;
    if (u) return scs_pkg::SCS_CODE_MIN;
    return v;
  endfunction : expect_code

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic convert(input logic [15:0] v, input logic o, u);
    logic [15:0] exp_code;
    int          n;
    exp_code = expect_code(v, o, u);
    @(posedge clk);
    vin <= v;
    over_range <= o;
    under_range <= u;
    convert_start <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("busy", 1'b1, busy)
    `CHK("plates", 1'b0, sw.plate_pos | sw.plate_neg)
    `CHK("track", 1'b1, sw.track)
    `CHK("power", 1'b1, power_on)
    // input moves after sampling, result must not follow it
    @(posedge clk) vin <= ~v;
    #1;
    `CHK("ground", 1'b1, sw.gnd & ~sw.track)
    repeat (5) @(posedge clk) convert_start <= ~convert_start;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("done", 1'b1, done)
    `CHK("code", exp_code, result)
    `CHK("idle", 1'b0, busy | power_on)
    `CHK("reacq", 1'b1, sw.track & sw.plate_pos & sw.plate_neg)
    @(posedge clk) convert_start <= 1'b0;
    #1;
    `CHK("pulse", 1'b0, done)
    repeat (4) @(posedge clk);
    #1;
    `CHK("held", exp_code, result)
  endtask : convert

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("rst code", scs_pkg::SCS_CODE_RST, result)
    foreach (corner[i]) convert(corner[i], 1'b0, 1'b0);
    convert(16'h1234, 1'b1, 1'b0);
    convert(16'h1234, 1'b0, 1'b1);
    convert(16'h4321, 1'b1, 1'b1);
    repeat (20) begin
      lfsr = lfsr_next(lfsr);
      convert(lfsr, 1'b0, 1'b0);
    end
    summarize();
  end

  // about 30 conversions of about 60 cycles each, with margin
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule : sar_conversion_sequencer_tb
`default_nettype wire
